/* bench/cpdc_partner.sv */
// Far-side model: consumers of the gated clock enables and wake sources.
// Assumes enable pulses in the crystal domain; counts them per consumer.
module cpdc_partner (
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   input  wire logic [2:0]  wake_req_i,
   input  wire logic [4:0]  pulse_i,
   output logic             pll_tick_o,
   output logic             x32k_tick_o,
   output logic             wake_gpio_o,
   output logic             wake_usb_o,
   output logic             wake_host_o,
   output logic [4:0][15:0] pulse_cnt_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] div_q = 4'h0;
   ////////////////////////////////////////////////////////////////////
   // Free-running source ticks, fixed ratios so counts are exact
   always_ff @(posedge clk_i) begin
      div_q <= div_q + 4'h1;
   end
   assign pll_tick_o  = (div_q[1:0] == 2'h3);
   assign x32k_tick_o = (div_q == 4'hF);
   assign wake_gpio_o = wake_req_i[0];
   assign wake_usb_o  = wake_req_i[1];
   assign wake_host_o = wake_req_i[2];
   ////////////////////////////////////////////////////////////////////
   // Unknown pulses are not counted, so they show up as a shortfall
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < 5; i++) begin
         if (srst_i) begin
            pulse_cnt_o[i] <= 16'h0000;
         end else if (pulse_i[i] === 1'b1) begin
            pulse_cnt_o[i] <= pulse_cnt_o[i] + 16'h0001;
         end
      end
   end
endmodule

/* bench/tb_top.sv */
// Self-checking bench for the clock and power-down controller.
// Assumes the partner model supplies ticks and wake levels.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic             clk_i = 1'b0;
   logic             srst_i = 1'b1;
   logic             wb_cyc = 1'b0;
   logic             wb_stb = 1'b0;
   logic             wb_we = 1'b0;
   logic [7:0]       wb_adr = 8'h00;
   logic [3:0]       wb_sel = 4'h0;
   logic [31:0]      wb_dat = 32'h0000_0000;
   logic [2:0]       wake_req = 3'h0;
   logic [31:0]      wb_dat_o;
   logic             wb_ack_o;
   logic             pll_tick;
   logic             x32k_tick;
   logic             wake_gpio;
   logic             wake_usb;
   logic             wake_host;
   logic             xtal_run_o;
   logic             pll_pd_o;
   wire logic [4:0]  pulse;
   logic [9:0]       apb_gate_o;
   logic             resume_irq_o;
   logic [4:0][15:0] cnt;
   logic [31:0]      exp_q[$];
   int               miscompares = 0;
   int               num_checks = 0;

   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   cpdc_top i_cpdc_top (.clk_i(clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pll_tick_i(pll_tick), .x32k_tick_i(x32k_tick),
      .wake_gpio_i(wake_gpio), .wake_usb_i(wake_usb), .wake_host_i(wake_host),
      .xtal_run_o(xtal_run_o), .pll_pd_o(pll_pd_o), .hclk_en_o(pulse[0]),
      .core_clk_gate_o(pulse[1]), .periph_bus_clk_gate_o(pulse[2]),
      .serial_flash_clk_gate_o(pulse[3]), .audio_unit_clk_gate_o(pulse[4]),
      .apb_gate_o(apb_gate_o), .resume_irq_o(resume_irq_o));

   cpdc_partner i_cpdc_partner (.clk_i(clk_i), .srst_i(srst_i), .wake_req_i(wake_req),
      .pulse_i(pulse), .pll_tick_o(pll_tick), .x32k_tick_o(x32k_tick),
      .wake_gpio_o(wake_gpio), .wake_usb_o(wake_usb), .wake_host_o(wake_host),
      .pulse_cnt_o(cnt));
   ////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want) begin
         miscompares++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask

   task automatic results();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic bail();
      miscompares++;
      results();
   endtask
   ////////////////////////////////////////////////////////////////////
   // Bus master: request held until the edge that samples ack
   task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d);
      int n;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= we;
      wb_adr <= a;
      wb_sel <= s;
      wb_dat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) bail();
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      exp_q.push_back(want);
      wb(1'b0, a, 4'hF, 32'h0000_0000);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, 4'hF, d);
   endtask

   // Pulses counted over n cycles, sampled off the active edge
   task automatic window(input int n, output logic [4:0][15:0] d);
      logic [4:0][15:0] s;
      @(negedge clk_i);
      s = cnt;
      repeat (n) @(negedge clk_i);
      for (int i = 0; i < 5; i++) d[i] = cnt[i] - s[i];
   endtask

   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_cyc && !wb_we) begin
         if (exp_q.size() == 0) bail();
         else check(wb_dat_o, exp_q.pop_front());
      end
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0]      r;
      logic [31:0]      m;
      logic [31:0]      v;
      logic [3:0]       s;
      logic [4:0][15:0] d;
      int               n;
      void'($urandom(32'h22eb));
      repeat (3) @(posedge clk_i);
      srst_i <= 1'b0;
      rd(cpdc_pkg::OFS_PWR, cpdc_pkg::RST_PWR);
      rd(cpdc_pkg::OFS_AHB, cpdc_pkg::RST_AHB);
      rd(cpdc_pkg::OFS_APB, cpdc_pkg::RST_APB);
      rd(cpdc_pkg::OFS_SEL, cpdc_pkg::RST_SEL);
      rd(cpdc_pkg::OFS_DIV0, cpdc_pkg::RST_DIV);
      rd(cpdc_pkg::OFS_PLL, cpdc_pkg::RST_PLL);
      // Default pre-scale wait is far too long for a run; skip it
      window(64, d);
      check(32'(d[0]), 32'h0000_0000);
      wr(cpdc_pkg::OFS_PWR, 32'h0000_0001);
      repeat (8) @(negedge clk_i);
      window(64, d);
      check(32'(d[0]), 32'h0000_0020);
      wr(8'h0C, 32'hFFFF_FFFF);
      rd(8'h0C, 32'h0000_0000);
      check(32'(xtal_run_o), 32'h0000_0001);
      $display("test reset done");
      r = $urandom();
      s = 4'($urandom());
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      wb(1'b1, cpdc_pkg::OFS_APB, s, r);
      v = ((cpdc_pkg::RST_APB & ~m) | (r & m)) & cpdc_pkg::MSK_APB;
      rd(cpdc_pkg::OFS_APB, v);
      check(32'(apb_gate_o), v & 32'h0000_03FF);
      r = $urandom();
      wr(cpdc_pkg::OFS_DIV1, r);
      rd(cpdc_pkg::OFS_DIV1, r & cpdc_pkg::MSK_DIV1);
      $display("test registers done");
      // Power down and wake from each source in turn
      for (int i = 0; i < 3; i++) begin
         v = {8'h00, 16'(i + 1), 5'h00, 1'(i != 1), 1'(i != 2), 1'b0};
         wr(cpdc_pkg::OFS_PWR, v);
         repeat (3) @(negedge clk_i);
         check(32'(xtal_run_o), 32'h0000_0000);
         rd(cpdc_pkg::OFS_PWR, v);
         @(posedge clk_i);
         wake_req <= 3'(1 << i);
         n = 0;
         while (xtal_run_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
         end
         if (n >= 50) bail();
         wake_req <= 3'h0;
         if (i != 2) begin
            window((i + 1) * 256 - 16, d);
            check(32'(d[0]), 32'h0000_0000);
            repeat (40) @(negedge clk_i);
         end else begin
            repeat (8) @(negedge clk_i);
         end
         window(64, d);
         check(32'(d[0]), 32'h0000_0020);
         rd(cpdc_pkg::OFS_PWR, v | 32'h0000_0009);
         check(32'(resume_irq_o), 32'(i != 1));
         wr(cpdc_pkg::OFS_PWR, v | 32'h0000_0001);
         rd(cpdc_pkg::OFS_PWR, v | 32'h0000_0009);
         wr(cpdc_pkg::OFS_PWR, v | 32'h0000_0009);
         rd(cpdc_pkg::OFS_PWR, v | 32'h0000_0001);
         check(32'(resume_irq_o), 32'h0000_0000);
      end
      $display("test wake done");
      wr(cpdc_pkg::OFS_PLL, 32'h0000_4035);
      repeat (3) @(negedge clk_i);
      check(32'(pll_pd_o), 32'h0000_0000);
      for (int k = 0; k < 4; k++) begin
         wr(cpdc_pkg::OFS_SEL, 32'(k));
         repeat (40) @(negedge clk_i);
         window(64, d);
         check(32'(d[0]), 32'h0000_0020 >> ((k == 0) ? 0 : k + 1));
      end
      wr(cpdc_pkg::OFS_SEL, 32'h0000_0000);
      $display("test select done");
      for (int k = 0; k < 2; k++) begin
         v = (k == 0) ? 32'h0000_0100 : 32'h0000_0083;
         wr(cpdc_pkg::OFS_AHB, v);
         rd(cpdc_pkg::OFS_AHB, v);
         repeat (8) @(negedge clk_i);
         window(64, d);
         check(32'(d[1]), v[0] ? 32'h0000_0020 : 32'h0000_0000);
         check(32'(d[2]), v[1] ? 32'h0000_0020 : 32'h0000_0000);
         check(32'(d[3]), v[7] ? 32'h0000_0020 : 32'h0000_0000);
         check(32'(d[4]), v[8] ? 32'h0000_0020 : 32'h0000_0000);
      end
      wr(cpdc_pkg::OFS_DIV0, 32'h0000_0040);
      repeat (8) @(negedge clk_i);
      window(64, d);
      check(32'(d[1]), 32'h0000_0020);
      check(32'(d[2]), 32'h0000_0010);
      $display("test gates done");
      results();
   end
endmodule

/* pkg/cpdc_pkg.sv */
// Package for the clock and power-down controller.
// Assumes a 32-bit classic Wishbone slave port, byte addressed.
package cpdc_pkg;
   localparam logic [7:0]  OFS_PWR    = 8'h00;
   localparam logic [7:0]  OFS_AHB    = 8'h04;
   localparam logic [7:0]  OFS_APB    = 8'h08;
   localparam logic [7:0]  OFS_SEL    = 8'h10;
   localparam logic [7:0]  OFS_DIV0   = 8'h14;
   localparam logic [7:0]  OFS_DIV1   = 8'h18;
   localparam logic [7:0]  OFS_PLL    = 8'h20;
   localparam logic [31:0] RST_PWR    = 32'h00FF_FF03;
   localparam logic [31:0] RST_AHB    = 32'h0000_0083;
   localparam logic [31:0] RST_APB    = 32'h0000_0007;
   localparam logic [31:0] RST_SEL    = 32'h0000_0000;
   localparam logic [31:0] RST_DIV    = 32'h0000_0000;
   localparam logic [31:0] RST_PLL    = 32'h0001_4035;
   localparam logic [31:0] MSK_PWR    = 32'h00FF_FF07;
   localparam logic [31:0] MSK_AHB    = 32'h0000_01C3;
   localparam logic [31:0] MSK_APB    = 32'h0000_037F;
   localparam logic [31:0] MSK_SEL    = 32'h0000_C0FF;
   localparam logic [31:0] MSK_DIV0   = 32'h00FF_FFCF;
   localparam logic [31:0] MSK_DIV1   = 32'h00FF_0000;
   localparam logic [31:0] MSK_PLL    = 32'h0007_FFFF;
   localparam int          B_XTAL     = 0;
   localparam int          B_WAKE     = 1;
   localparam int          B_IEN      = 2;
   localparam int          B_FLAG     = 3;
   localparam int          PS_LO      = 8;
   localparam int          PS_W       = 16;
   localparam int          B_CORE     = 0;
   localparam int          B_PBUS     = 1;
   localparam int          B_SFLASH   = 7;
   localparam int          B_AUDIO    = 8;
   localparam int          SEL_W      = 2;
   localparam int          HDIV_W     = 4;
   localparam int          PDIV_LO    = 6;
   localparam int          PDIV_W     = 2;
   localparam int          WAKE_SHIFT = 8;
   localparam int          WCNT_W     = PS_W + WAKE_SHIFT;
   localparam logic [1:0]  SRC_XTAL   = 2'h0;
   localparam logic [1:0]  SRC_PLL    = 2'h1;
   localparam logic [1:0]  SRC_PLL2   = 2'h2;
   localparam logic [1:0]  SRC_X32K   = 2'h3;
   typedef enum logic [1:0] {PWR_RUN, PWR_DOWN, PWR_WAIT} cpdc_pwr_t;
endpackage

/* src/cpdc_top.sv */
// Clock and power-down controller: registers, wake counter, clock enables.
// Assumes a classic Wishbone master on clk_i (crystal clock), and source
// clocks delivered as clock-enable ticks sampled in this domain.
//
// Overview of operation
// R1: AHB clock is chosen source halved
// R2: Core at AHB rate, peripheral bus divided
// R3: PLL referenced from crystal, serves as source
// R4: Per-module gating, source select and dividers
// R5: Crystal-run bit zero stops oscillator
// R6: Wake waits pre-scale times 256 crystal cycles
// R7: Wake-counter bit selects wait or skip
// R8: Interrupt on crystal-run rise when enabled
// R9: Resume flag set on rise, write-one clears
// R10: GPIO, USB, host wake-ups resume too
// R11: Bit 8 gates audio unit clock
// R12: Bit 7 gates serial flash clocks
// R13: Power-down register reset value
// R14: AHB enable register reset value
// R15: Bit 1 peripheral bus, bit 0 core
// R16: Two-bit AHB source select field
// R17: Clocks held during wake count, released clean
//
// Our own choice: the Wishbone register port.
module cpdc_top (
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        pll_tick_i,
   input  wire logic        x32k_tick_i,
   input  wire logic        wake_gpio_i,
   input  wire logic        wake_usb_i,
   input  wire logic        wake_host_i,
   output logic             xtal_run_o,
   output logic             pll_pd_o,
   output logic             hclk_en_o,
   output logic             core_clk_gate_o,
   output logic             periph_bus_clk_gate_o,
   output logic             serial_flash_clk_gate_o,
   output logic             audio_unit_clk_gate_o,
   output logic      [9:0]  apb_gate_o,
   output logic             resume_irq_o
);

   ////////////////////////////////////////////////////////////////////////
   // Register bank
   logic [31:0] pwr_q;
   logic [31:0] ahb_q;
   logic [31:0] apb_q;
   logic [31:0] sel_q;
   logic [31:0] div0_q;
   logic [31:0] div1_q;
   logic [31:0] pll_q;
   logic        wr_stb;
   logic [31:0] wr_mask;
   logic        rise;
   logic        wake_req;
   logic [2:0]  ext_s1_q;
   logic [2:0]  ext_s2_q;
   logic [1:0]  tick_s1_q;
   logic [1:0]  tick_s2_q;

   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [31:0] m);
      merge = (old_v & ~m) | (new_v & m);
   endfunction

   assign wr_stb  = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
   assign wr_mask = lane_mask(wb_sel_i);

   // Two-flop synchronisers for pins and foreign-clock ticks
   always_ff @(posedge clk_i) begin
      ext_s1_q  <= {wake_host_i, wake_usb_i, wake_gpio_i};
      ext_s2_q  <= ext_s1_q;
      tick_s1_q <= {x32k_tick_i, pll_tick_i};
      tick_s2_q <= tick_s1_q;
   end

   // R10: any wake source
   assign wake_req = |ext_s2_q;

   // Ack one cycle, then drop; every address answers
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
         unique case (wb_adr_i)
            cpdc_pkg::OFS_PWR:  wb_dat_o <= pwr_q;
            cpdc_pkg::OFS_AHB:  wb_dat_o <= ahb_q;
            cpdc_pkg::OFS_APB:  wb_dat_o <= apb_q;
            cpdc_pkg::OFS_SEL:  wb_dat_o <= sel_q;
            cpdc_pkg::OFS_DIV0: wb_dat_o <= div0_q;
            cpdc_pkg::OFS_DIV1: wb_dat_o <= div1_q;
            cpdc_pkg::OFS_PLL:  wb_dat_o <= pll_q;
            default:            wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // R13: power-down register, flag is write-one-clear
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pwr_q <= cpdc_pkg::RST_PWR;
      end else begin
         if (wr_stb && wb_adr_i == cpdc_pkg::OFS_PWR) begin
            pwr_q <= merge(pwr_q, wb_dat_i, wr_mask & cpdc_pkg::MSK_PWR);
            // R9: write one clears
            if (wr_mask[cpdc_pkg::B_FLAG] && wb_dat_i[cpdc_pkg::B_FLAG]) begin
               pwr_q[cpdc_pkg::B_FLAG] <= 1'b0;
            end else begin
               pwr_q[cpdc_pkg::B_FLAG] <= pwr_q[cpdc_pkg::B_FLAG];
            end
         end
         // R5: hardware wake re-runs crystal
         if (wake_req && !pwr_q[cpdc_pkg::B_XTAL]) begin
            pwr_q[cpdc_pkg::B_XTAL] <= 1'b1;
         end
         // R9: set wins over clear
         if (rise) begin
            pwr_q[cpdc_pkg::B_FLAG] <= 1'b1;
         end
      end
   end

   // R14: AHB enable reset value; other banks
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ahb_q  <= cpdc_pkg::RST_AHB;
         apb_q  <= cpdc_pkg::RST_APB;
         sel_q  <= cpdc_pkg::RST_SEL;
         div0_q <= cpdc_pkg::RST_DIV;
         div1_q <= cpdc_pkg::RST_DIV;
         pll_q  <= cpdc_pkg::RST_PLL;
      end else if (wr_stb) begin
         unique case (wb_adr_i)
            cpdc_pkg::OFS_AHB:  ahb_q  <= merge(ahb_q, wb_dat_i, wr_mask & cpdc_pkg::MSK_AHB);
            cpdc_pkg::OFS_APB:  apb_q  <= merge(apb_q, wb_dat_i, wr_mask & cpdc_pkg::MSK_APB);
            cpdc_pkg::OFS_SEL:  sel_q  <= merge(sel_q, wb_dat_i, wr_mask & cpdc_pkg::MSK_SEL);
            cpdc_pkg::OFS_DIV0: div0_q <= merge(div0_q, wb_dat_i, wr_mask & cpdc_pkg::MSK_DIV0);
            cpdc_pkg::OFS_DIV1: div1_q <= merge(div1_q, wb_dat_i, wr_mask & cpdc_pkg::MSK_DIV1);
            cpdc_pkg::OFS_PLL:  pll_q  <= merge(pll_q, wb_dat_i, wr_mask & cpdc_pkg::MSK_PLL);
            default:            ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power state and wake counter
   cpdc_pkg::cpdc_pwr_t         st_q;
   logic                        xtal_d1_q;
   logic [cpdc_pkg::WCNT_W-1:0] wcnt_q;
   logic                        first_q;
   logic                        clk_ok_q;

   assign rise = pwr_q[cpdc_pkg::B_XTAL] && !xtal_d1_q;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         xtal_d1_q <= 1'b1;
      end else begin
         xtal_d1_q <= pwr_q[cpdc_pkg::B_XTAL];
      end
   end

   // R7: wait after reset only if wake counter on
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         first_q <= 1'b1;
      end else begin
         first_q <= 1'b0;
      end
   end

   // R6: count pre-scale times 256
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_q   <= cpdc_pkg::PWR_WAIT;
         wcnt_q <= '0;
      end else begin
         unique case (st_q)
            cpdc_pkg::PWR_RUN: begin
               if (!pwr_q[cpdc_pkg::B_XTAL]) begin
                  st_q <= cpdc_pkg::PWR_DOWN;
               end
            end
            cpdc_pkg::PWR_DOWN: begin
               wcnt_q <= '0;
               if (pwr_q[cpdc_pkg::B_XTAL]) begin
                  st_q <= cpdc_pkg::PWR_WAIT;
               end
            end
            cpdc_pkg::PWR_WAIT: begin
               if (!pwr_q[cpdc_pkg::B_XTAL]) begin
                  st_q <= cpdc_pkg::PWR_DOWN;
               end else if (!pwr_q[cpdc_pkg::B_WAKE] ||
                            wcnt_q >= {pwr_q[cpdc_pkg::PS_LO +: cpdc_pkg::PS_W],
                                       8'h00}) begin
                  st_q   <= cpdc_pkg::PWR_RUN;
                  wcnt_q <= '0;
               end else if (!first_q) begin
                  wcnt_q <= wcnt_q + 1'b1;
               end
            end
         endcase
      end
   end

   // R17: clocks held until wake ends
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         clk_ok_q <= 1'b0;
      end else begin
         clk_ok_q <= (st_q == cpdc_pkg::PWR_RUN) && pwr_q[cpdc_pkg::B_XTAL];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AHB and peripheral clock enables
   logic                        src_tick;
   logic                        half_q;
   logic [cpdc_pkg::HDIV_W-1:0] hcnt_q;
   logic [cpdc_pkg::PDIV_W-1:0] pcnt_q;
   logic                        hclk_tick;
   logic                        pll2_q;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pll2_q <= 1'b0;
      end else if (tick_s2_q[0]) begin
         pll2_q <= ~pll2_q;
      end
   end

   // R16: source selection  R3: PLL as source
   always_comb begin
      unique case (sel_q[cpdc_pkg::SEL_W-1:0])
         cpdc_pkg::SRC_XTAL: src_tick = 1'b1;
         cpdc_pkg::SRC_PLL:  src_tick = tick_s2_q[0] && !pll_q[16];
         cpdc_pkg::SRC_PLL2: src_tick = tick_s2_q[0] && pll2_q && !pll_q[16];
         cpdc_pkg::SRC_X32K: src_tick = tick_s2_q[1];
      endcase
   end

   // R1: halve, then divide by N+1
   always_ff @(posedge clk_i) begin
      if (srst_i || !clk_ok_q) begin
         half_q <= 1'b0;
         hcnt_q <= '0;
      end else if (src_tick) begin
         half_q <= ~half_q;
         if (half_q) begin
            hcnt_q <= (hcnt_q == div0_q[cpdc_pkg::HDIV_W-1:0]) ? '0 : hcnt_q + 1'b1;
         end
      end
   end

   assign hclk_tick = clk_ok_q && src_tick && half_q &&
                      (hcnt_q == div0_q[cpdc_pkg::HDIV_W-1:0]);

   // R2: peripheral bus divided from AHB
   always_ff @(posedge clk_i) begin
      if (srst_i || !clk_ok_q) begin
         pcnt_q <= '0;
      end else if (hclk_tick) begin
         pcnt_q <= (pcnt_q == div0_q[cpdc_pkg::PDIV_LO +: cpdc_pkg::PDIV_W]) ?
                   '0 : pcnt_q + 1'b1;
      end
   end

   // R4: per-module gating  R11  R12  R15
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         hclk_en_o               <= 1'b0;
         core_clk_gate_o         <= 1'b0;
         periph_bus_clk_gate_o   <= 1'b0;
         serial_flash_clk_gate_o <= 1'b0;
         audio_unit_clk_gate_o   <= 1'b0;
         apb_gate_o              <= '0;
      end else begin
         hclk_en_o               <= hclk_tick;
         core_clk_gate_o         <= hclk_tick && ahb_q[cpdc_pkg::B_CORE];
         periph_bus_clk_gate_o   <= hclk_tick && ahb_q[cpdc_pkg::B_PBUS] &&
                                    pcnt_q == div0_q[cpdc_pkg::PDIV_LO +: cpdc_pkg::PDIV_W];
         serial_flash_clk_gate_o <= hclk_tick && ahb_q[cpdc_pkg::B_SFLASH];
         audio_unit_clk_gate_o   <= hclk_tick && ahb_q[cpdc_pkg::B_AUDIO];
         apb_gate_o              <= clk_ok_q ? apb_q[9:0] : '0;
      end
   end

   // R5: crystal control  R8: resume interrupt
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         xtal_run_o   <= 1'b1;
         pll_pd_o     <= 1'b0;
         resume_irq_o <= 1'b0;
      end else begin
         xtal_run_o   <= pwr_q[cpdc_pkg::B_XTAL];
         pll_pd_o     <= pll_q[16] || !pwr_q[cpdc_pkg::B_XTAL];
         resume_irq_o <= pwr_q[cpdc_pkg::B_FLAG] && pwr_q[cpdc_pkg::B_IEN];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   flag_set_a: assert property (@(posedge clk_i) disable iff (srst_i) // R9
      rise |=> pwr_q[cpdc_pkg::B_FLAG])
      else $error("resume flag not set on rise");
   irq_follow_a: assert property (@(posedge clk_i) disable iff (srst_i) // R8
      pwr_q[cpdc_pkg::B_FLAG] && pwr_q[cpdc_pkg::B_IEN] |=> resume_irq_o)
      else $error("resume interrupt missing");
   hold_wait_a: assert property (@(posedge clk_i) disable iff (srst_i) // R17
      st_q != cpdc_pkg::PWR_RUN |=> !hclk_tick)
      else $error("clock leaked during wake");
   skip_wait_a: assert property (@(posedge clk_i) disable iff (srst_i) // R7
      st_q == cpdc_pkg::PWR_WAIT && pwr_q[cpdc_pkg::B_XTAL] && !pwr_q[cpdc_pkg::B_WAKE]
      |=> st_q == cpdc_pkg::PWR_RUN)
      else $error("wait not skipped");
   xtal_down_a: assert property (@(posedge clk_i) disable iff (srst_i) // R5
      !pwr_q[cpdc_pkg::B_XTAL] |=> !xtal_run_o && !clk_ok_q)
      else $error("crystal not stopped");
   audio_gate_a: assert property (@(posedge clk_i) disable iff (srst_i) // R11
      !ahb_q[cpdc_pkg::B_AUDIO] |=> !audio_unit_clk_gate_o)
      else $error("audio clock not gated");
   flash_gate_a: assert property (@(posedge clk_i) disable iff (srst_i) // R12
      !ahb_q[cpdc_pkg::B_SFLASH] |=> !serial_flash_clk_gate_o)
      else $error("flash clock not gated");
   core_gate_a: assert property (@(posedge clk_i) disable iff (srst_i) // R15
      !ahb_q[cpdc_pkg::B_CORE] |=> !core_clk_gate_o)
      else $error("core clock not gated");
   ahb_half_a: assert property (@(posedge clk_i) disable iff (srst_i) // R1
      hclk_tick |=> !hclk_tick)
      else $error("ahb tick not halved");
   wake_res_a: assert property (@(posedge clk_i) disable iff (srst_i) // R10
      wake_req && !pwr_q[cpdc_pkg::B_XTAL] |=> pwr_q[cpdc_pkg::B_XTAL])
      else $error("wake source ignored");
endmodule
